//--- hw/output_channel_clock_divider.sv
/*
 * Channel clock divider feeding a group of three clock outputs, with its
 * registers, sync handling, forcing, bypass, direct routing and duty-cycle
 * correction. Assumes a register port driven by the serial control port
 * logic on CLOCK, DIST_TICK marking each distribution clock cycle, a
 * global divider-mode bit from the same domain and an asynchronous SYNC.
 */
`timescale 1ns/1ps
`default_nettype none

module output_channel_clock_divider
    import chan_div_pkg::*;
(
    // Clock and reset
    input  wire logic                     CLOCK,
    input  wire logic                     SYS_RST,
    // Distribution clock cycle marker
    input  wire logic                     DIST_TICK,
    // Chip-level controls
    input  wire logic                     SYNC_REQ,
    input  wire logic                     GLOBAL_DIV_MODE,
    input  wire logic [`GROUP_OUTS-1:0]   OUT_INVERT,
    // Register port
    input  wire logic [`REG_ADDR_W-1:0]   REG_ADDR,
    input  wire logic [`REG_DATA_W-1:0]   REG_WDATA,
    input  wire logic                     REG_WR,
    input  wire logic                     REG_RD,
    output logic      [`REG_DATA_W-1:0]   REG_RDATA,
    // Group outputs and status
    output logic      [`GROUP_OUTS-1:0]   GROUP_OUT,
    output logic                          GROUP_PWR_DOWN,
    output logic                          DIV_OUT
);

    // All state of this module
    typedef struct packed {
        logic [7:0]             ch2_ctrl;
        logic [7:0]             route_pwr;
        logic [7:0]             half_per;
        logic [7:0]             ch3_ctrl;
        logic [7:0]             rdata;
        logic                   sync_meta;
        logic                   sync_lvl;
        logic                   dist_lvl;
        logic                   prev_div;
        logic                   dcc_lvl;
        logic [`CNT_W-1:0]      dcc_cnt;
        logic                   div_out;
        logic [`GROUP_OUTS-1:0] grp_out;
        logic                   pwr_down;
    } top_s;

    top_s     cur_ff;
    top_s     nxt_cur;
    div_cfg_s cfg;
    logic     core_hold;
    logic     core_lvl;
    logic     obey_sync;
    logic     forcing;
    logic     direct;
    logic     bypass;
    logic     div_src;
    logic     grp_src;
    logic [`CNT_W-1:0] dcc_high;

    // Settings for the core
    assign cfg.low_cnt    = cur_ff.half_per[`HP_LOW_MSB:`HP_LOW_LSB];
    assign cfg.high_cnt   = cur_ff.half_per[`HP_HIGH_MSB:`HP_HIGH_LSB];
    assign cfg.start_high = cur_ff.ch3_ctrl[`CTL_START_HIGH];
    assign cfg.phase      = cur_ff.ch3_ctrl[`CTL_PHASE_MSB:`CTL_PHASE_LSB];

    // Mode decode
    assign bypass    = cur_ff.ch3_ctrl[`CTL_BYPASS];
    assign obey_sync = ~cur_ff.ch3_ctrl[`CTL_IGNORE_SYNC];
    assign forcing   = cur_ff.ch3_ctrl[`CTL_IGNORE_SYNC] & cur_ff.sync_lvl;
    assign direct    = cur_ff.route_pwr[`RP_DIRECT_OUT] & ~GLOBAL_DIV_MODE;
    assign core_hold = bypass | (obey_sync & cur_ff.sync_lvl);

    // High time of the corrected clock: half the period, rounded up
    // Sum taken six bits wide so that fifteen plus fifteen plus three cannot wrap
    assign dcc_high = 5'(({2'b00, cfg.low_cnt} + {2'b00, cfg.high_cnt} + 6'h03) >> 1);

    half_period_core u_core (
        .clock   (CLOCK),
        .sys_rst (SYS_RST),
        .tick    (DIST_TICK),
        .hold    (core_hold),
        .cfg     (cfg),
        .lvl     (core_lvl)
    );

    // Level leaving the divider stage
    always_comb begin
        if (bypass) begin
            div_src = cur_ff.dist_lvl;
        end else if (forcing) begin
            div_src = cur_ff.ch3_ctrl[`CTL_FORCE_HIGH]
                    ? cur_ff.ch3_ctrl[`CTL_START_HIGH] : 1'b0;
        end else if (!cur_ff.route_pwr[`RP_DCC_DISABLE]) begin
            div_src = cur_ff.dcc_lvl;
        end else begin
            div_src = core_lvl;
        end
        grp_src = direct ? cur_ff.dist_lvl : div_src;
    end

    // Next state
    always_comb begin
        nxt_cur = cur_ff;
        // Sync pin synchroniser
        nxt_cur.sync_meta = SYNC_REQ;
        nxt_cur.sync_lvl  = cur_ff.sync_meta;
        // Reconstructed distribution clock level
        if (DIST_TICK) begin
            nxt_cur.dist_lvl = ~cur_ff.dist_lvl;
        end
        // Duty-cycle correction follows each rising edge of the core
        nxt_cur.prev_div = core_lvl;
        if (core_lvl && !cur_ff.prev_div) begin
            nxt_cur.dcc_lvl = 1'b1;
            nxt_cur.dcc_cnt = dcc_high - 5'h01;
        end else if (DIST_TICK) begin
            if (cur_ff.dcc_cnt != '0) begin
                nxt_cur.dcc_cnt = cur_ff.dcc_cnt - 5'h01;
            end else begin
                nxt_cur.dcc_lvl = 1'b0;
            end
        end
        // Register writes
        if (REG_WR) begin
            case (REG_ADDR)
                `OFS_CH2_DIV_CTRL:     nxt_cur.ch2_ctrl  = REG_WDATA;
                `OFS_CH2_ROUTE_PWR:    nxt_cur.route_pwr = REG_WDATA & `RP_USED_MASK;
                `OFS_CH3_HALF_PERIODS: nxt_cur.half_per  = REG_WDATA;
                `OFS_CH3_DIV_CTRL:     nxt_cur.ch3_ctrl  = REG_WDATA;
                default:               nxt_cur.ch2_ctrl  = cur_ff.ch2_ctrl;
            endcase
        end
        // Register reads, unmapped addresses read zero
        if (REG_RD) begin
            case (REG_ADDR)
                `OFS_CH2_DIV_CTRL:     nxt_cur.rdata = cur_ff.ch2_ctrl;
                `OFS_CH2_ROUTE_PWR:    nxt_cur.rdata = cur_ff.route_pwr;
                `OFS_CH3_HALF_PERIODS: nxt_cur.rdata = cur_ff.half_per;
                `OFS_CH3_DIV_CTRL:     nxt_cur.rdata = cur_ff.ch3_ctrl;
                default:               nxt_cur.rdata = 8'h00;
            endcase
        end
        // Output stage
        nxt_cur.div_out  = div_src;
        nxt_cur.pwr_down = cur_ff.route_pwr[`RP_POWER_DOWN];
        if (cur_ff.route_pwr[`RP_POWER_DOWN]) begin
            nxt_cur.grp_out = '0;
        end else begin
            nxt_cur.grp_out = {`GROUP_OUTS{grp_src}} ^ OUT_INVERT;
        end
    end

    // State register
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cur_ff           <= '0;
            cur_ff.ch2_ctrl  <= `RST_CH2_DIV_CTRL;
            cur_ff.route_pwr <= `RST_CH2_ROUTE_PWR;
            cur_ff.half_per  <= `RST_CH3_HALF_PERIODS;
            cur_ff.ch3_ctrl  <= `RST_CH3_DIV_CTRL;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs straight from flip-flops
    assign REG_RDATA      = cur_ff.rdata;
    assign GROUP_OUT      = cur_ff.grp_out;
    assign GROUP_PWR_DOWN = cur_ff.pwr_down;
    assign DIV_OUT        = cur_ff.div_out;

endmodule

`default_nettype wire

//--- hw/chan_div_consts.svh
/*
 * Register offsets, field positions, reset values and widths of the
 * channel clock divider. Assumes nothing; definitions only.
 */
`ifndef CHAN_DIV_CONSTS_SVH
`define CHAN_DIV_CONSTS_SVH

// Register offsets on the serial control port address space
`define OFS_CH2_DIV_CTRL      10'h197
`define OFS_CH2_ROUTE_PWR     10'h198
`define OFS_CH3_HALF_PERIODS  10'h199
`define OFS_CH3_DIV_CTRL      10'h19A

// Field positions in the half-period register
`define HP_LOW_MSB            7
`define HP_LOW_LSB            4
`define HP_HIGH_MSB           3
`define HP_HIGH_LSB           0

// Field positions in a divider control register
`define CTL_BYPASS            7
`define CTL_IGNORE_SYNC       6
`define CTL_FORCE_HIGH        5
`define CTL_START_HIGH        4
`define CTL_PHASE_MSB         3
`define CTL_PHASE_LSB         0

// Field positions in the routing and power register
`define RP_POWER_DOWN         2
`define RP_DIRECT_OUT         1
`define RP_DCC_DISABLE        0
`define RP_USED_MASK          8'h07

// Reset values
`define RST_CH2_DIV_CTRL      8'h00
`define RST_CH2_ROUTE_PWR     8'h00
`define RST_CH3_HALF_PERIODS  8'h00
`define RST_CH3_DIV_CTRL      8'h00

// Widths
`define REG_ADDR_W            10
`define REG_DATA_W            8
`define CNT_W                 5
`define GROUP_OUTS            3

`endif

//--- hw/chan_div_pkg.sv
/*
 * Types shared by the channel clock divider files.
 * Assumes chan_div_consts.svh is on the include path.
 */
`include "chan_div_consts.svh"

package chan_div_pkg;

    // Settings handed from the register file to the divider core
    typedef struct packed {
        logic [3:0] low_cnt;
        logic [3:0] high_cnt;
        logic       start_high;
        logic [3:0] phase;
    } div_cfg_s;

    // Divider core phases
    typedef enum logic [1:0] {
        DIV_HOLD  = 2'b00,
        DIV_DELAY = 2'b01,
        DIV_RUN   = 2'b10
    } div_state_e;

    // Divider core state
    typedef struct packed {
        div_state_e               st;
        logic [`CNT_W-1:0]        cnt;
        logic                     lvl;
    } core_s;

endpackage

//--- hw/half_period_core.sv
/*
 * Half-period counter: produces the divided level from input clock ticks.
 * Assumes TICK is a one-cycle pulse per distribution clock cycle on CLOCK.
 */
`timescale 1ns/1ps
`default_nettype none

module half_period_core
    import chan_div_pkg::*;
(
    // Clock and reset
    input  wire logic     clock,
    input  wire logic     sys_rst,
    // Control
    input  wire logic     tick,
    input  wire logic     hold,
    input  wire div_cfg_s cfg,
    // Divided level
    output logic          lvl
);

    core_s cur_ff;
    core_s nxt_cur;

    // Next state of the divider
    always_comb begin
        nxt_cur = cur_ff;
        if (hold) begin
            nxt_cur.st  = DIV_DELAY;
            nxt_cur.cnt = {1'b0, cfg.phase};
            nxt_cur.lvl = cfg.start_high;
        end else if (tick) begin
            case (cur_ff.st)
                DIV_HOLD: begin
                    nxt_cur.st  = DIV_DELAY;
                    nxt_cur.cnt = {1'b0, cfg.phase};
                    nxt_cur.lvl = cfg.start_high;
                end
                DIV_DELAY: begin
                    if (cur_ff.cnt == '0) begin
                        nxt_cur.st  = DIV_RUN;
                        nxt_cur.cnt = cfg.start_high ? {1'b0, cfg.high_cnt}
                                                     : {1'b0, cfg.low_cnt};
                    end else begin
                        nxt_cur.cnt = cur_ff.cnt - 5'h01;
                    end
                end
                DIV_RUN: begin
                    if (cur_ff.cnt == '0) begin
                        nxt_cur.lvl = ~cur_ff.lvl;
                        nxt_cur.cnt = cur_ff.lvl ? {1'b0, cfg.low_cnt}
                                                 : {1'b0, cfg.high_cnt};
                    end else begin
                        nxt_cur.cnt = cur_ff.cnt - 5'h01;
                    end
                end
                default: begin
                    nxt_cur.st = DIV_HOLD;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cur_ff <= '{st: DIV_HOLD, cnt: '0, lvl: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign lvl = cur_ff.lvl;

endmodule

`default_nettype wire

//--- bench/chan_div_sva.sv
/* Port checker for the channel clock divider.
   Assumes binding to output_channel_clock_divider, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "chan_div_consts.svh"
module chan_div_chk
(
    // Clock, reset and controls
    input wire logic       CLOCK,
    input wire logic       SYS_RST,
    input wire logic       DIST_TICK,
    input wire logic       SYNC_REQ,
    input wire logic       GLOBAL_DIV_MODE,
    input wire logic [2:0] OUT_INVERT,
    // Register port
    input wire logic [9:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    // Outputs
    input wire logic [2:0] GROUP_OUT,
    input wire logic       GROUP_PWR_DOWN,
    input wire logic       DIV_OUT
);
    logic [7:0] hp_ff;
    logic [7:0] ctl_ff;
    logic [2:0] rp_ff;
    logic [5:0] quiet_ff;
    logic [4:0] run_ff;
    logic       lvl_ff;
    logic [5:0] gap_ff;
    logic [5:0] sync_exp;
    // Cycles from sync release to the first divider edge, pipeline included
    assign sync_exp = 6'h05 + {2'b00, ctl_ff[3:0]}
                    + {2'b00, ctl_ff[4] ? hp_ff[3:0] : hp_ff[7:4]};
    // Shadow settings, settled-time and run-length counters
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            hp_ff <= 8'h00;
            ctl_ff <= 8'h00;
            rp_ff <= 3'h0;
            quiet_ff <= 6'h00;
            run_ff <= 5'h00;
            lvl_ff <= 1'b0;
            gap_ff <= 6'h3F;
        end else begin
            if (REG_WR && REG_ADDR == `OFS_CH3_HALF_PERIODS) hp_ff <= REG_WDATA;
            if (REG_WR && REG_ADDR == `OFS_CH3_DIV_CTRL) ctl_ff <= REG_WDATA;
            if (REG_WR && REG_ADDR == `OFS_CH2_ROUTE_PWR) rp_ff <= REG_WDATA[2:0];
            if (REG_WR || !DIST_TICK || SYNC_REQ || $changed(GLOBAL_DIV_MODE)
                || $changed(OUT_INVERT)) quiet_ff <= 6'h00;
            else if (quiet_ff != 6'h3F) quiet_ff <= quiet_ff + 6'h01;
            run_ff <= (DIV_OUT != lvl_ff) ? 5'h01 : run_ff + 5'h01;
            lvl_ff <= DIV_OUT;
            gap_ff <= SYNC_REQ ? 6'h00 : (gap_ff == 6'h3F) ? gap_ff : gap_ff + 6'h01;
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    low_len_a: assert property ($rose(DIV_OUT) && quiet_ff == 6'h3F && !ctl_ff[7] && rp_ff[0]
        |-> run_ff == {1'b0, hp_ff[7:4]} + 5'h01) else $error("low time wrong");
    high_len_a: assert property ($fell(DIV_OUT) && quiet_ff == 6'h3F && !ctl_ff[7] && rp_ff[0]
        |-> run_ff == {1'b0, hp_ff[3:0]} + 5'h01) else $error("high time wrong");
    bypass_pass_a: assert property (ctl_ff[7] && rp_ff[0] && quiet_ff == 6'h3F
        |=> DIV_OUT != $past(DIV_OUT)) else $error("bypass not passing input");
    sync_hold_a: assert property ((!ctl_ff[6] && !ctl_ff[7] && rp_ff[0] && SYNC_REQ && !REG_WR)[*6]
        |-> DIV_OUT == ctl_ff[4]) else $error("sync hold level wrong");
    force_lvl_a: assert property ((ctl_ff[6] && !ctl_ff[7] && rp_ff[0] && SYNC_REQ && !REG_WR)[*6]
        |-> DIV_OUT == (ctl_ff[5] & ctl_ff[4])) else $error("forced level wrong");
    pwr_safe_a: assert property (rp_ff[2][*2]
        |=> GROUP_PWR_DOWN && GROUP_OUT == 3'h0) else $error("power-down outputs wrong");
    direct_route_a: assert property (rp_ff[1] && !GLOBAL_DIV_MODE && !rp_ff[2]
        && quiet_ff == 6'h3F |=> GROUP_OUT == ~$past(GROUP_OUT)) else $error("direct route wrong");
    mode_block_a: assert property ((!rp_ff[1] || GLOBAL_DIV_MODE) && !rp_ff[2]
        && quiet_ff == 6'h3F |=> GROUP_OUT == ({3{DIV_OUT}} ^ $past(OUT_INVERT)))
        else $error("group outputs not from divider");
    dcc_high_a: assert property ($fell(DIV_OUT) && quiet_ff == 6'h3F && !ctl_ff[7] && !rp_ff[0]
        |-> {1'b0, run_ff} == ({2'b00, hp_ff[7:4]} + {2'b00, hp_ff[3:0]} + 6'h03) >> 1)
        else $error("corrected high time wrong");
    phase_hold_a: assert property (!ctl_ff[6] && !ctl_ff[7] && rp_ff[0] && gap_ff != 6'h00
        && gap_ff < sync_exp |-> $stable(DIV_OUT)) else $error("divider moved inside offset");
    phase_edge_a: assert property (!ctl_ff[6] && !ctl_ff[7] && rp_ff[0] && gap_ff == sync_exp
        |-> $changed(DIV_OUT)) else $error("first edge after sync misplaced");
endmodule
bind output_channel_clock_divider chan_div_chk chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .DIST_TICK(DIST_TICK), .SYNC_REQ(SYNC_REQ), .GLOBAL_DIV_MODE(GLOBAL_DIV_MODE),
    .OUT_INVERT(OUT_INVERT), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .GROUP_OUT(GROUP_OUT),
    .GROUP_PWR_DOWN(GROUP_PWR_DOWN), .DIV_OUT(DIV_OUT));
`default_nettype wire

//--- bench/output_channel_clock_divider_tb.sv
/* Self-checking bench for the channel clock divider.
   Assumes the checker is bound; DIST_TICK is held high every cycle. */
`timescale 1ns/1ps
`default_nettype none
`include "chan_div_consts.svh"
module output_channel_clock_divider_tb;
    logic       CLOCK, SYS_RST, DIST_TICK, SYNC_REQ, GLOBAL_DIV_MODE, REG_WR, REG_RD;
    logic       GROUP_PWR_DOWN, DIV_OUT;
    logic       lvl_q = 1'b0;
    logic       rd_q = 1'b0;
    logic [5:0] p, h;
    logic [7:0] ctl_seq [5] = '{8'h15, 8'h70, 8'h60, 8'hF0, 8'h80};
    logic [2:0] OUT_INVERT, GROUP_OUT;
    logic [9:0] REG_ADDR;
    logic [7:0] REG_WDATA, REG_RDATA, v;
    logic [4:0] run = 5'h00;
    logic [7:0] rq[$];
    logic [4:0] hq[$], lq[$];
    int         miscompares, compares;
    // Clock
    always #50 CLOCK = ~CLOCK;
    output_channel_clock_divider dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .DIST_TICK(DIST_TICK),
        .SYNC_REQ(SYNC_REQ), .GLOBAL_DIV_MODE(GLOBAL_DIV_MODE), .OUT_INVERT(OUT_INVERT),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .GROUP_OUT(GROUP_OUT), .GROUP_PWR_DOWN(GROUP_PWR_DOWN),
        .DIV_OUT(DIV_OUT));
    // Compare helpers
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_run(input logic [4:0] got, input logic [4:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: run %0d expected %0d", $time, got, exp);
        end
    endtask
    // Register port cycles
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        rq.push_back(e);
        @(posedge CLOCK);
        REG_RD <= 1'b0;
    endtask
    task automatic stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Monitor: read data and divider run lengths against queued notes
    always @(posedge CLOCK) begin
        rd_q <= REG_RD;
        lvl_q <= DIV_OUT;
        run <= (DIV_OUT !== lvl_q) ? 5'h01 : run + 5'h01;
        if (rd_q) chk_byte(REG_RDATA, rq.pop_front());
        if (DIV_OUT !== lvl_q && lvl_q && hq.size() > 0) chk_run(run, hq.pop_front());
        if (DIV_OUT !== lvl_q && !lvl_q && lq.size() > 0) chk_run(run, lq.pop_front());
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge CLOCK);
        miscompares++;
        stop_test;
    end
    // Main sequence
    initial begin
        {CLOCK, DIST_TICK, SYS_RST} = 3'h3;
        {SYNC_REQ, GLOBAL_DIV_MODE, REG_WR, REG_RD} = 4'h0;
        {OUT_INVERT, REG_ADDR, REG_WDATA} = 21'h0;
        {miscompares, compares} = 64'h0;
        void'($urandom(32'h28AF051F));
        repeat (4) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        for (int a = 'h197; a <= 'h19B; a++) rd(a[9:0], 8'h00);
        for (int a = 'h197; a <= 'h19B; a++) begin
            v = 8'($urandom);
            wr(a[9:0], v);
            rd(a[9:0], a == 'h19B ? 8'h00 : a == 'h198 ? v & `RP_USED_MASK : v);
        end
        $display("test registers done");
        wr(`OFS_CH2_ROUTE_PWR, 8'h01);
        wr(`OFS_CH3_DIV_CTRL, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = (i % 4 == 0) ? 8'h00 : (i % 4 == 1) ? 8'hFF : 8'($urandom);
            if (i == 4) wr(`OFS_CH2_ROUTE_PWR, 8'h00);
            wr(`OFS_CH3_HALF_PERIODS, v);
            repeat (70) @(posedge CLOCK);
            p = {2'b00, v[7:4]} + {2'b00, v[3:0]} + 6'h02;
            h = (i < 4) ? {2'b00, v[3:0]} + 6'h01 : (p + 6'h01) >> 1;
            hq.push_back(5'(h));
            lq.push_back(5'(p - h));
            repeat (40) @(posedge CLOCK);
        end
        wr(`OFS_CH2_ROUTE_PWR, 8'h01);
        $display("test half periods done");
        OUT_INVERT <= 3'($urandom);
        foreach (ctl_seq[k]) begin
            v = ctl_seq[k];
            wr(`OFS_CH3_DIV_CTRL, v);
            SYNC_REQ <= 1'b1;
            repeat (12) @(posedge CLOCK);
            SYNC_REQ <= 1'b0;
            repeat (70) @(posedge CLOCK);
        end
        $display("test sync force bypass done");
        wr(`OFS_CH3_DIV_CTRL, 8'h00);
        for (int m = 0; m < 2; m++) begin
            GLOBAL_DIV_MODE <= m[0];
            wr(`OFS_CH2_ROUTE_PWR, 8'h03);
            repeat (70) @(posedge CLOCK);
            wr(`OFS_CH2_ROUTE_PWR, 8'h05);
            repeat (10) @(posedge CLOCK);
        end
        $display("test routing power done");
        stop_test;
    end
endmodule
`default_nettype wire
